// >>> logic/iad_pkg.sv
// constants for the i2c abort-cause and dma request block
package iad_pkg;

  // wishbone data and address widths
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;

  // register byte addresses
  localparam logic [31:0] MASTER_CFG_OFF = 32'h5000_1300;
  localparam logic [31:0] ABORT_CLR_OFF = 32'h5000_1354;
  localparam logic [31:0] ABORT_SRC_OFF = 32'h5000_1380;
  localparam logic [31:0] DMA_CTL_OFF = 32'h5000_1388;
  localparam logic [31:0] TX_WM_OFF = 32'h5000_138c;
  localparam logic [31:0] RX_WM_OFF = 32'h5000_1390;

  // abort-cause field positions
  localparam int START_BYTE_NO_RESTART_BIT = 9;
  localparam int HIGH_SPEED_NO_RESTART_BIT = 8;
  localparam int START_BYTE_ACKED_BIT = 7;
  localparam int HS_CODE_ACKED_BIT = 6;
  localparam int GENERAL_CALL_READ_BIT = 5;
  localparam int GENERAL_CALL_NACK_BIT = 4;
  localparam int DATA_NACK_BIT = 3;
  localparam int TEN_BIT_SECOND_NACK_BIT = 2;
  localparam int TEN_BIT_FIRST_NACK_BIT = 1;
  localparam int SEVEN_BIT_ADDR_NACK_BIT = 0;
  localparam int ABORT_W = 10;

  // master configuration field positions
  localparam int REPEATED_START_ENABLE_BIT = 0;
  localparam int COMMAND_SELECT_A_BIT = 1;
  localparam int GENERAL_CALL_OR_START_BIT = 2;
  localparam int CFG_W = 3;

  // dma control field positions
  localparam int TX_DMA_ENABLE_BIT = 1;
  localparam int RX_DMA_ENABLE_BIT = 0;
  localparam int DMA_CTL_W = 2;

  // watermark and fifo count widths
  localparam int LEVEL_W = 5;
  localparam int FIFO_CNT_W = 6;

  // reset values
  localparam logic [2:0] CFG_RST = 3'h0;
  localparam logic [9:0] ABORT_RST = 10'h000;
  localparam logic [1:0] DMA_CTL_RST = 2'h0;
  localparam logic [4:0] TX_WM_RST = 5'h00;
  localparam logic [4:0] RX_WM_RST = 5'h00;

  // kind of byte that the bus engine has just sent
  typedef enum logic [2:0] {
    KIND_ADDR7 = 3'h0,
    KIND_ADDR10_FIRST = 3'h1,
    KIND_ADDR10_SECOND = 3'h2,
    KIND_DATA = 3'h3,
    KIND_GENERAL_CALL = 3'h4,
    KIND_START_BYTE = 3'h5,
    KIND_HS_CODE = 3'h6
  } iad_byte_kind_t;

endpackage : iad_pkg

// >>> logic/iad_core.sv
// abort-cause recording and dma request logic with a wishbone slave
`timescale 1ns/1ps

// Notes on behaviour
// [R1] start byte without restart sets bit 9
// [R2] bit 9 cleared under cause reasserts next cycle
// [R3] software removes start-byte cause before clearing
// [R4] high-speed transfer without restart sets bit 8
// [R5] acknowledged start byte sets bit 7
// [R6] acknowledged high-speed master code sets bit 6
// [R7] general call then read command sets bit 5
// [R8] unacknowledged general call sets bit 4
// [R9] master data byte not acknowledged sets bit 3
// [R10] ten-bit second address byte nack sets bit 2
// [R11] ten-bit first address byte nack sets bit 1
// [R12] seven-bit address nack sets bit 0
// [R13] dma control bit 1 enables transmit dma
// [R14] dma control bit 0 enables receive dma
// [R15] tx request when level at or below watermark
// [R16] rx request when level above rx watermark
// [R17] abort bits read-only, cleared together by software
// [R18] dma keeps serving request until it drops
module iad_core (
  input wire logic clk_i, // 25 MHz clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic ce_i, // clock enable, freezes state when low
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [31:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte selects
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  input wire logic master_xfer_pending_i, // master has a transfer queued
  input wire logic hs_mode_i, // master configured for high speed
  input wire logic master_mode_i, // controller acting as master
  input wire logic tx_ack_event_i, // pulse: remote acked sent byte
  input wire logic tx_nack_event_i, // pulse: remote nacked sent byte
  input wire logic [2:0] tx_byte_kind_i, // kind of the byte just sent
  input wire logic next_cmd_read_i, // next queued command is a read
  input wire logic [5:0] tx_fifo_level_i, // transmit fifo entries
  input wire logic [5:0] rx_fifo_level_i, // receive fifo entries
  output logic tx_abort_o, // pulse: new abort cause latched
  output logic [2:0] master_cfg_o, // restart enable and target select
  output logic dma_tx_req_o, // transmit dma request
  output logic dma_rx_req_o // receive dma request
);

  // address decode used by every register
  function automatic logic addr_hit(input logic [31:0] adr,
                                    input logic [31:0] off);
    addr_hit = (adr[31:2] == off[31:2]);
  endfunction : addr_hit

  // byte-lane merge for 16-bit registers
  function automatic logic [15:0] lane_merge(input logic [15:0] old_val,
                                             input logic [15:0] new_val,
                                             input logic [1:0] sel);
    lane_merge[7:0] = sel[0] ? new_val[7:0] : old_val[7:0];
    lane_merge[15:8] = sel[1] ? new_val[15:8] : old_val[15:8];
  endfunction : lane_merge

  logic ack_reg;
  logic [31:0] dat_reg;
  logic [2:0] cfg_reg;
  logic [9:0] src_reg;
  logic [9:0] src_next;
  logic [1:0] dma_ctl_reg;
  logic [4:0] tx_wm_reg;
  logic [4:0] rx_wm_reg;
  logic abort_pulse_reg;

  // bus request decode
  wire bus_req = wb_cyc_i & wb_stb_i;
  wire rd_take = ce_i & bus_req & ~ack_reg;
  wire wr_fire = ce_i & bus_req & wb_we_i & ack_reg;
  wire hit_cfg = addr_hit(wb_adr_i, iad_pkg::MASTER_CFG_OFF);
  wire hit_clr = addr_hit(wb_adr_i, iad_pkg::ABORT_CLR_OFF);
  wire hit_src = addr_hit(wb_adr_i, iad_pkg::ABORT_SRC_OFF);
  wire hit_ctl = addr_hit(wb_adr_i, iad_pkg::DMA_CTL_OFF);
  wire hit_txw = addr_hit(wb_adr_i, iad_pkg::TX_WM_OFF);
  wire hit_rxw = addr_hit(wb_adr_i, iad_pkg::RX_WM_OFF);
  wire [15:0] wr_merge_cfg = lane_merge({13'h0000, cfg_reg},
                                        wb_dat_i[15:0], wb_sel_i[1:0]);
  wire [15:0] wr_merge_ctl = lane_merge({14'h0000, dma_ctl_reg},
                                        wb_dat_i[15:0], wb_sel_i[1:0]);
  wire [15:0] wr_merge_txw = lane_merge({11'h000, tx_wm_reg},
                                        wb_dat_i[15:0], wb_sel_i[1:0]);
  wire [15:0] wr_merge_rxw = lane_merge({11'h000, rx_wm_reg},
                                        wb_dat_i[15:0], wb_sel_i[1:0]);

  // read mux, unmapped and write-only addresses read as zero
  wire [31:0] rd_mux =
    hit_cfg ? {29'h0000_0000, cfg_reg} :
    hit_src ? {22'h00_0000, src_reg} :
    hit_ctl ? {30'h0000_0000, dma_ctl_reg} :
    hit_txw ? {27'h000_0000, tx_wm_reg} :
    hit_rxw ? {27'h000_0000, rx_wm_reg} :
    32'h0000_0000;

  // configuration fields steering the abort conditions
  wire restart_en =
    cfg_reg[iad_pkg::REPEATED_START_ENABLE_BIT];
  wire command_select_a = cfg_reg[iad_pkg::COMMAND_SELECT_A_BIT];
  wire general_call_or_start_select =
    cfg_reg[iad_pkg::GENERAL_CALL_OR_START_BIT];

  // byte kind decode
  wire kind_addr7 = (tx_byte_kind_i == iad_pkg::KIND_ADDR7);
  wire kind_a10_1 = (tx_byte_kind_i == iad_pkg::KIND_ADDR10_FIRST);
  wire kind_a10_2 = (tx_byte_kind_i == iad_pkg::KIND_ADDR10_SECOND);
  wire kind_data = (tx_byte_kind_i == iad_pkg::KIND_DATA);
  wire kind_gcall = (tx_byte_kind_i == iad_pkg::KIND_GENERAL_CALL);
  wire kind_sbyte = (tx_byte_kind_i == iad_pkg::KIND_START_BYTE);
  wire kind_hs = (tx_byte_kind_i == iad_pkg::KIND_HS_CODE);

  // abort conditions
  wire sbyte_cond = ~restart_en & command_select_a &
                    general_call_or_start_select & master_xfer_pending_i; // R1
  wire hs_cond = ~restart_en & hs_mode_i & master_xfer_pending_i; // R4
  wire start_byte_no_restart_abort = sbyte_cond;
  wire high_speed_no_restart_abort = hs_cond;
  wire start_byte_acked_abort = tx_ack_event_i & kind_sbyte; // R5
  wire hs_code_acked_abort = tx_ack_event_i & kind_hs & hs_mode_i; // R6
  wire general_call_read_abort =
    tx_ack_event_i & kind_gcall & next_cmd_read_i; // R7
  wire general_call_nack_abort = tx_nack_event_i & kind_gcall; // R8
  wire data_nack_abort =
    tx_nack_event_i & kind_data & master_mode_i; // R9
  wire ten_bit_second_nack_abort = tx_nack_event_i & kind_a10_2; // R10
  wire ten_bit_first_nack_abort = tx_nack_event_i & kind_a10_1; // R11
  wire seven_bit_addr_nack_abort = tx_nack_event_i & kind_addr7; // R12

  wire [9:0] set_vec = {
    start_byte_no_restart_abort,
    high_speed_no_restart_abort,
    start_byte_acked_abort,
    hs_code_acked_abort,
    general_call_read_abort,
    general_call_nack_abort,
    data_nack_abort,
    ten_bit_second_nack_abort,
    ten_bit_first_nack_abort,
    seven_bit_addr_nack_abort
  };

  // software clear of all abort bits: write one to bit 0 of clear word
  wire abort_clr = wr_fire & hit_clr & wb_sel_i[0] & wb_dat_i[0]; // R17

  // per-bit next value: a new event beats the clear, except bit 9
  // which drops for one cycle even while its cause stands
  genvar gi;
  generate
    for (gi = 0; gi < iad_pkg::ABORT_W; gi = gi + 1)
    begin : g_abort
      if (gi == iad_pkg::START_BYTE_NO_RESTART_BIT)
      begin : g_sbyte
        assign src_next[gi] = abort_clr ? 1'b0 :
                              (src_reg[gi] | set_vec[gi]); // R2
      end
      else
      begin : g_other
        assign src_next[gi] = set_vec[gi] |
                              (src_reg[gi] & ~abort_clr); // R17
      end
    end
  endgenerate

  // wishbone acknowledge and read data
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      ack_reg <= bus_req & ~ack_reg;
      if (rd_take)
      begin
        dat_reg <= rd_mux;
      end
    end
  end

  // software-written registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg_reg <= iad_pkg::CFG_RST;
      dma_ctl_reg <= iad_pkg::DMA_CTL_RST;
      tx_wm_reg <= iad_pkg::TX_WM_RST;
      rx_wm_reg <= iad_pkg::RX_WM_RST;
    end
    else if (wr_fire)
    begin
      if (hit_cfg)
      begin
        cfg_reg <= wr_merge_cfg[2:0];
      end
      if (hit_ctl)
      begin
        dma_ctl_reg <= wr_merge_ctl[1:0]; // R13 R14
      end
      if (hit_txw)
      begin
        tx_wm_reg <= wr_merge_txw[4:0];
      end
      if (hit_rxw)
      begin
        rx_wm_reg <= wr_merge_rxw[4:0];
      end
    end
  end

  // abort-cause register, read-only from the bus
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      src_reg <= iad_pkg::ABORT_RST;
      abort_pulse_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      src_reg <= src_next; // R1 R17
      abort_pulse_reg <= |(set_vec & ~src_reg);
    end
  end

  // dma requests; the dma engine fills tx and drains rx until these fall
  wire tx_dma_enable = dma_ctl_reg[iad_pkg::TX_DMA_ENABLE_BIT];
  wire rx_dma_enable = dma_ctl_reg[iad_pkg::RX_DMA_ENABLE_BIT];
  wire [5:0] tx_wm_ext = {1'b0, tx_wm_reg};
  wire [5:0] rx_wm_plus = {1'b0, rx_wm_reg} + 6'h01;

  assign dma_tx_req_o = tx_dma_enable &
                        (tx_fifo_level_i <= tx_wm_ext); // R15 R18
  assign dma_rx_req_o = rx_dma_enable &
                        (rx_fifo_level_i >= rx_wm_plus); // R16 R18

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign tx_abort_o = abort_pulse_reg;
  assign master_cfg_o = cfg_reg; // R3

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_clr_under_cause;
    ce_i && sbyte_cond && abort_clr;
  endsequence

  sequence s_ctl_write;
    wr_fire && hit_ctl && wb_sel_i[0];
  endsequence

  a_sbyte_sets: assert property ( // R1
    ce_i && sbyte_cond && !abort_clr |=> src_reg[9])
    else $error("start byte abort bit not set");

  a_sbyte_drop: assert property ( // R2
    s_clr_under_cause |=> !src_reg[9])
    else $error("start byte abort bit did not drop on clear");

  a_sbyte_back: assert property ( // R2
    s_clr_under_cause ##1 (ce_i && sbyte_cond && !abort_clr)
      |=> src_reg[9])
    else $error("start byte abort bit not reasserted");

  a_hs_norestart: assert property ( // R4
    ce_i && hs_cond |=> src_reg[8])
    else $error("high speed no restart bit not set");

  a_sbyte_acked: assert property ( // R5
    ce_i && tx_ack_event_i && kind_sbyte |=> src_reg[7])
    else $error("acked start byte bit not set");

  a_hs_acked: assert property ( // R6
    ce_i && tx_ack_event_i && kind_hs && hs_mode_i |=> src_reg[6])
    else $error("acked hs code bit not set");

  a_gcall_read: assert property ( // R7
    ce_i && tx_ack_event_i && kind_gcall && next_cmd_read_i
      |=> src_reg[5])
    else $error("general call read bit not set");

  a_gcall_nack: assert property ( // R8
    ce_i && tx_nack_event_i && kind_gcall |=> src_reg[4])
    else $error("general call nack bit not set");

  a_data_nack: assert property ( // R9
    ce_i && !abort_clr && !src_reg[3] && !(tx_nack_event_i &&
      kind_data && master_mode_i) |=> !src_reg[3])
    else $error("data nack bit set without cause");

  a_data_set: assert property ( // R9
    ce_i && tx_nack_event_i && kind_data && master_mode_i |=> src_reg[3])
    else $error("data nack bit not set");

  a_ten_second: assert property ( // R10
    ce_i && tx_nack_event_i && kind_a10_2 |=> src_reg[2])
    else $error("ten bit second nack bit not set");

  a_ten_first: assert property ( // R11
    ce_i && tx_nack_event_i && kind_a10_1 |=> src_reg[1])
    else $error("ten bit first nack bit not set");

  a_seven_addr: assert property ( // R12
    ce_i && tx_nack_event_i && kind_addr7 |=> src_reg[0] && tx_abort_o
      || $past(src_reg[0]))
    else $error("seven bit address nack bit not set");

  a_tx_dma_en: assert property ( // R13
    s_ctl_write |=> dma_ctl_reg[1] == $past(wb_dat_i[1]))
    else $error("transmit dma enable not written");

  a_rx_dma_en: assert property ( // R14
    s_ctl_write |=> dma_ctl_reg[0] == $past(wb_dat_i[0]))
    else $error("receive dma enable not written");

  a_tx_req_level: assert property ( // R15
    dma_tx_req_o |-> tx_fifo_level_i <= {1'b0, tx_wm_reg}
      && dma_ctl_reg[1])
    else $error("transmit request above watermark");

  a_rx_req_level: assert property ( // R16
    rx_fifo_level_i == {1'b0, rx_wm_reg} |-> !dma_rx_req_o)
    else $error("receive request at watermark without excess");

  a_clr_empties: assert property ( // R17
    ce_i && abort_clr && set_vec == 10'h000 |=> src_reg == 10'h000)
    else $error("abort bits not cleared");

  a_src_readonly: assert property ( // R17
    wr_fire && hit_src && set_vec == 10'h000 |=> $stable(src_reg))
    else $error("abort register changed by bus write");

endmodule : iad_core

// >>> verification/iad_far_model.sv
// dma controller model that fills and drains the fifo levels on request
`timescale 1ns/1ps
module iad_far_model (
  input wire logic clk_i, // clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic slow_i, // serve only every other cycle
  input wire logic [5:0] tx_init_i, // tx level after reset
  input wire logic [5:0] rx_init_i, // rx level after reset
  input wire logic dma_tx_req_i, // transmit request
  input wire logic dma_rx_req_i, // receive request
  output logic [5:0] tx_level_o, // transmit fifo entries
  output logic [5:0] rx_level_o // receive fifo entries
);
  logic phase_reg;
  wire logic serve = !slow_i || phase_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      phase_reg <= 1'b0;
      tx_level_o <= tx_init_i;
      rx_level_o <= rx_init_i;
    end
    else
    begin
      phase_reg <= !phase_reg;
      // one entry per transfer while the request stands
      if (dma_tx_req_i && serve)
        tx_level_o <= tx_level_o + 6'h01;
      if (dma_rx_req_i && serve)
        rx_level_o <= rx_level_o - 6'h01;
    end
  end
endmodule : iad_far_model

// >>> verification/i2c_abort_dma_request_test.sv
// self-checking bench for the abort-cause and dma request block
`timescale 1ns/1ps
module i2c_abort_dma_request_test;
  typedef struct packed {
    logic [3:0] ack_kind;
    logic [2:0] mm_rd_hs;
    logic [9:0] bits;
  } iad_row_t;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, tx_abort_o;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, q;
  logic [3:0] wb_sel_i;
  logic pend_i, hs_i, mm_i, ack_ev, nack_ev, rd_i, slow_i, ce_i;
  logic [2:0] kind_i, master_cfg_o;
  logic [5:0] tx_lvl, rx_lvl;
  logic dma_tx_req_o, dma_rx_req_o;
  iad_row_t rows [10];
  int n_fail, n_checks, cycles, n;

  iad_core iad_core_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .master_xfer_pending_i(pend_i), .hs_mode_i(hs_i), .master_mode_i(mm_i),
    .tx_ack_event_i(ack_ev), .tx_nack_event_i(nack_ev),
    .tx_byte_kind_i(kind_i), .next_cmd_read_i(rd_i),
    .tx_fifo_level_i(tx_lvl), .rx_fifo_level_i(rx_lvl),
    .tx_abort_o(tx_abort_o), .master_cfg_o(master_cfg_o),
    .dma_tx_req_o(dma_tx_req_o), .dma_rx_req_o(dma_rx_req_o));
  iad_far_model iad_far_model_i (.clk_i(clk_i), .rst_i(rst_i),
    .slow_i(slow_i), .tx_init_i(6'h00), .rx_init_i(6'h0a),
    .dma_tx_req_i(dma_tx_req_o), .dma_rx_req_i(dma_rx_req_o),
    .tx_level_o(tx_lvl), .rx_level_o(rx_lvl));

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  // one classic cycle; entered just after a rising edge
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'h3;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (wb_ack_o !== 1'b1 && k < 20);
    if (k == 20)
      n_fail++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic rdc(input string what, input logic [31:0] a,
                     input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(what, e, q);
  endtask : rdc

  task automatic fire(input iad_row_t r);
    {mm_i, rd_i, hs_i} <= r.mm_rd_hs;
    kind_i <= r.ack_kind[2:0];
    ack_ev <= r.ack_kind[3];
    nack_ev <= !r.ack_kind[3];
    @(posedge clk_i);
    ack_ev <= 1'b0;
    nack_ev <= 1'b0;
    @(posedge clk_i);
    chk("abort pulse", {31'h0, r.bits != 10'h0}, {31'h0, tx_abort_o});
  endtask : fire

  initial
  begin
    clk_i = 1'b0;
    forever
      #20 clk_i = ~clk_i;
  end

  initial
  begin
    cycles = 0;
    forever
    begin
      @(posedge clk_i);
      cycles++;
      if (cycles == 3000)
      begin
        n_fail++;
        conclude();
      end
    end
  end

  initial
  begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i} <= 4'h8;
    {wb_adr_i, wb_dat_i, wb_sel_i} <= '0;
    {pend_i, hs_i, mm_i, ack_ev, nack_ev, rd_i, slow_i, kind_i} <= '0;
    ce_i <= 1'b1;
    rows[0] = {4'h0, 3'h4, 10'h001};
    rows[1] = {4'h1, 3'h4, 10'h002};
    rows[2] = {4'h2, 3'h4, 10'h004};
    rows[3] = {4'h3, 3'h4, 10'h008};
    rows[4] = {4'h3, 3'h0, 10'h000};
    rows[5] = {4'h4, 3'h4, 10'h010};
    rows[6] = {4'hc, 3'h6, 10'h020};
    rows[7] = {4'hd, 3'h4, 10'h080};
    rows[8] = {4'he, 3'h5, 10'h040};
    rows[9] = {4'he, 3'h4, 10'h000};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 10; i++)
    begin
      bus(1'b1, iad_pkg::ABORT_CLR_OFF, 32'h1);
      fire(rows[i]);
      rdc("abort bits", iad_pkg::ABORT_SRC_OFF, {22'h0, rows[i].bits});
    end
    pend_i <= 1'b1;
    bus(1'b1, iad_pkg::MASTER_CFG_OFF, 32'h6);
    chk("cfg", 32'h6, {29'h0, master_cfg_o});
    rdc("start no restart", iad_pkg::ABORT_SRC_OFF, 32'h200);
    bus(1'b1, iad_pkg::ABORT_CLR_OFF, 32'h1);
    n = 0;
    while (tx_abort_o !== 1'b1 && n < 4)
    begin
      @(posedge clk_i);
      n++;
    end
    chk("re-set pulse", 32'h1, {31'h0, tx_abort_o});
    rdc("bit 9 back", iad_pkg::ABORT_SRC_OFF, 32'h200);
    bus(1'b1, iad_pkg::MASTER_CFG_OFF, 32'h7);
    bus(1'b1, iad_pkg::ABORT_CLR_OFF, 32'h1);
    rdc("cause fixed", iad_pkg::ABORT_SRC_OFF, 32'h0);
    // raise high speed before restart is disabled, so bit 8 is
    // already latched when the read below is taken
    hs_i <= 1'b1;
    bus(1'b1, iad_pkg::MASTER_CFG_OFF, 32'h0);
    rdc("hs no restart", iad_pkg::ABORT_SRC_OFF, 32'h100);
    hs_i <= 1'b0;
    pend_i <= 1'b0;
    bus(1'b1, iad_pkg::ABORT_SRC_OFF, 32'h3ff);
    rdc("read only", iad_pkg::ABORT_SRC_OFF, 32'h100);
    rdc("unmapped", 32'h5000_13f0, 32'h0);
    bus(1'b1, iad_pkg::TX_WM_OFF, 32'h4);
    bus(1'b1, iad_pkg::RX_WM_OFF, 32'h2);
    rdc("tx mark", iad_pkg::TX_WM_OFF, 32'h4);
    rdc("rx mark", iad_pkg::RX_WM_OFF, 32'h2);
    chk("req off", 32'h0, {dma_tx_req_o, dma_rx_req_o});
    slow_i <= 1'b1;
    bus(1'b1, iad_pkg::DMA_CTL_OFF, 32'h3);
    rdc("dma ctl", iad_pkg::DMA_CTL_OFF, 32'h3);
    n = 0;
    while ({dma_tx_req_o, dma_rx_req_o} !== 2'b00 && n < 60)
    begin
      @(posedge clk_i);
      n++;
    end
    chk("tx level", 32'h5, {26'h0, tx_lvl});
    chk("rx level", 32'h2, {26'h0, rx_lvl});
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc("abort reset", iad_pkg::ABORT_SRC_OFF, 32'h0);
    rdc("ctl reset", iad_pkg::DMA_CTL_OFF, 32'h0);
    rdc("mark reset", iad_pkg::TX_WM_OFF, 32'h0);
    // an event while the clock enable is low must leave no trace
    ce_i <= 1'b0;
    kind_i <= 3'h0;
    nack_ev <= 1'b1;
    @(posedge clk_i);
    nack_ev <= 1'b0;
    ce_i <= 1'b1;
    @(posedge clk_i);
    chk("frozen pulse", 32'h0, {31'h0, tx_abort_o});
    rdc("frozen bits", iad_pkg::ABORT_SRC_OFF, 32'h0);
    conclude();
  end
endmodule : i2c_abort_dma_request_test
